// file: hdl/dual_dac_pkg.sv
// constants for the two-converter data latch and control block
// assumes an 8-bit register bus that runs on the same clock as the block
package dual_dac_pkg;
  // register addresses on the core's register bus, one set per converter
  localparam logic [7:0] LOW_ADDR  [2] = '{8'hd2, 8'hd5};
  localparam logic [7:0] HIGH_ADDR [2] = '{8'hd3, 8'hd6};
  localparam logic [7:0] CTRL_ADDR [2] = '{8'hd4, 8'hd7};
  // control register layout
  localparam int         ENABLE_BIT   = 7;
  localparam int         FMT_MSB      = 2;
  localparam int         FMT_LSB      = 0;
  localparam logic [7:0] DATA_RESET   = 8'h00;
  localparam logic [2:0] FMT_RESET    = 3'h0;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  // data format codes: high byte carries 4, 5, 6, 7 or 8 upper bits
  localparam logic [2:0] FMT_NYBBLE = 3'h0;
  localparam logic [2:0] FMT_FIVE   = 3'h1;
  localparam logic [2:0] FMT_SIX    = 3'h2;
  localparam logic [2:0] FMT_SEVEN  = 3'h3;
  localparam int         FMT_BYTE_BIT = 2;  // any 1xx code
  localparam int         CODE_WIDTH = 12;
  localparam logic [11:0] CODE_RESET = 12'h000;
endpackage : dual_dac_pkg

// file: hdl/dual_dac_latch.sv
// data byte registers, control registers and code latch for two converters
// assumes the core's register strobes are single-cycle and synchronous to mclk
`timescale 1ns/100ps
module dual_dac_latch (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // register bus from the core
  input  wire logic [7:0]  sfrAddr,
  input  wire logic        sfrWrite,
  input  wire logic        sfrRead,
  input  wire logic [7:0]  sfrWdata,
  output logic      [7:0]  sfrRdata,
  output logic             sfrHit,
  // converter 0 analogue controls
  output logic      [11:0] convCode0,
  output logic             convEnable0,
  output logic             convOutEnableN0,
  output logic             convShutdown0,
  // converter 1 analogue controls
  output logic      [11:0] convCode1,
  output logic             convEnable1,
  output logic             convOutEnableN1,
  output logic             convShutdown1
);

  localparam int NCONV = 2;

  // address tables and byte placements are written for two converters and a 12-bit code
  if ($size(dual_dac_pkg::LOW_ADDR) != NCONV ||
      dual_dac_pkg::CODE_WIDTH != 12) begin : g_size_check
    $error("address table or code width does not fit this block");
  end

  typedef struct packed {
    logic [NCONV-1:0][7:0]  low;
    logic [NCONV-1:0][7:0]  high;
    logic [NCONV-1:0][11:0] code;
    logic [NCONV-1:0]       en;
    logic [NCONV-1:0][2:0]  fmt;
    logic [7:0]             rdata;
  } state_s;

  state_s stateQ;
  state_s stateD;

  // place the 12-bit word from the byte pair according to the format code
  function automatic logic [11:0] assemble(input logic [2:0] fmt, input logic [7:0] hi,
                                           input logic [7:0] lo);
    logic [11:0] word;
    word = dual_dac_pkg::CODE_RESET;
    if (fmt[dual_dac_pkg::FMT_BYTE_BIT]) begin
      word = {hi, lo[7:4]};
    end else begin
      case (fmt)
        dual_dac_pkg::FMT_NYBBLE: word = {hi[3:0], lo};
        dual_dac_pkg::FMT_FIVE:   word = {hi[4:0], lo[7:1]};
        dual_dac_pkg::FMT_SIX:    word = {hi[5:0], lo[7:2]};
        dual_dac_pkg::FMT_SEVEN:  word = {hi[6:0], lo[7:3]};
        default:                  word = {hi, lo[7:4]};
      endcase
    end
    return word;
  endfunction : assemble

  // combinational hit for the core's decode
  always_comb begin
    sfrHit = 1'b0;
    for (int i = 0; i < NCONV; i++) begin
      if (sfrAddr == dual_dac_pkg::LOW_ADDR[i] || sfrAddr == dual_dac_pkg::HIGH_ADDR[i] ||
          sfrAddr == dual_dac_pkg::CTRL_ADDR[i]) begin
        sfrHit = 1'b1;
      end
    end
  end

  // next state: register writes, code latch and registered read data
  always_comb begin
    stateD = stateQ;
    for (int i = 0; i < NCONV; i++) begin
      if (sfrWrite) begin
        // low byte stored, no latch here
        if (sfrAddr == dual_dac_pkg::LOW_ADDR[i]) begin
          stateD.low[i] = sfrWdata;
        end
        // high byte write latches the code
        if (sfrAddr == dual_dac_pkg::HIGH_ADDR[i]) begin
          stateD.high[i] = sfrWdata;
          stateD.code[i] = assemble(stateQ.fmt[i], sfrWdata, stateQ.low[i]);
        end
        // enable bit, format field, unused bits dropped
        if (sfrAddr == dual_dac_pkg::CTRL_ADDR[i]) begin
          stateD.en[i]  = sfrWdata[dual_dac_pkg::ENABLE_BIT];
          stateD.fmt[i] = sfrWdata[dual_dac_pkg::FMT_MSB:dual_dac_pkg::FMT_LSB];
        end
      end
    end
    // read data is held until the next read so a slow core can sample it
    if (sfrRead) begin
      stateD.rdata = dual_dac_pkg::READ_UNMAPPED;
      for (int i = 0; i < NCONV; i++) begin
        if (sfrAddr == dual_dac_pkg::LOW_ADDR[i]) begin
          stateD.rdata = stateQ.low[i];
        end
        if (sfrAddr == dual_dac_pkg::HIGH_ADDR[i]) begin
          stateD.rdata = stateQ.high[i];
        end
        if (sfrAddr == dual_dac_pkg::CTRL_ADDR[i]) begin
          stateD.rdata = {stateQ.en[i], 4'h0, stateQ.fmt[i]};
        end
      end
    end
  end

  // everything resets to zero, converters disabled
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NCONV; i++) begin
        stateQ.low[i]  <= dual_dac_pkg::DATA_RESET;
        stateQ.high[i] <= dual_dac_pkg::DATA_RESET;
        stateQ.code[i] <= dual_dac_pkg::CODE_RESET;
        stateQ.fmt[i]  <= dual_dac_pkg::FMT_RESET;
      end
      stateQ.en    <= '0;
      stateQ.rdata <= dual_dac_pkg::READ_UNMAPPED;
    end else begin
      stateQ <= stateD;
    end
  end

  // outputs straight from the state flops
  assign sfrRdata        = stateQ.rdata;
  // unsigned code drives the converter directly
  assign convCode0       = stateQ.code[0];
  assign convCode1       = stateQ.code[1];
  assign convEnable0     = stateQ.en[0];
  assign convEnable1     = stateQ.en[1];
  // disabled means high impedance and shutdown
  assign convOutEnableN0 = ~stateQ.en[0];
  assign convOutEnableN1 = ~stateQ.en[1];
  assign convShutdown0   = ~stateQ.en[0];
  assign convShutdown1   = ~stateQ.en[1];

  // checks on the latch and register behaviour
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_low_no_latch: assert property (
    sfrWrite && sfrAddr == dual_dac_pkg::LOW_ADDR[0] && !$past(reset) |=> $stable(convCode0))
    else $error("low byte write changed code");
  a_code_cause: assert property (
    $changed(convCode0) |-> $past(sfrWrite) && $past(sfrAddr) == dual_dac_pkg::HIGH_ADDR[0])
    else $error("code changed without high byte write");
  a_code1_cause: assert property (
    $changed(convCode1) |-> $past(sfrWrite) && $past(sfrAddr) == dual_dac_pkg::HIGH_ADDR[1])
    else $error("converter 1 code changed without high byte write");
  // a format change alone must not re-latch the old bytes
  a_ctrl_no_latch: assert property (
    sfrWrite && sfrAddr == dual_dac_pkg::CTRL_ADDR[0] |=> $stable(convCode0))
    else $error("control write changed code");
  a_fmt_nybble: assert property (
    sfrWrite && sfrAddr == dual_dac_pkg::HIGH_ADDR[0] && stateQ.fmt[0] == 3'h0
    |=> convCode0 == {$past(sfrWdata[3:0]), $past(stateQ.low[0])})
    else $error("format 000 placement wrong");
  a_fmt_seven: assert property (
    sfrWrite && sfrAddr == dual_dac_pkg::HIGH_ADDR[0] && stateQ.fmt[0] == 3'h3
    |=> convCode0 == {$past(sfrWdata[6:0]), $past(stateQ.low[0][7:3])})
    else $error("format 011 placement wrong");
  a_fmt_five: assert property (
    sfrWrite && sfrAddr == dual_dac_pkg::HIGH_ADDR[0] && stateQ.fmt[0] == 3'h1
    |=> convCode0 == {$past(sfrWdata[4:0]), $past(stateQ.low[0][7:1])})
    else $error("format 001 placement wrong");
  a_fmt_six: assert property (
    sfrWrite && sfrAddr == dual_dac_pkg::HIGH_ADDR[0] && stateQ.fmt[0] == 3'h2
    |=> convCode0 == {$past(sfrWdata[5:0]), $past(stateQ.low[0][7:2])})
    else $error("format 010 placement wrong");
  a_conv1_byte: assert property (
    sfrWrite && sfrAddr == dual_dac_pkg::HIGH_ADDR[1] && stateQ.fmt[1][2]
    |=> convCode1 == {$past(sfrWdata), $past(stateQ.low[1][7:4])})
    else $error("converter 1 format 1xx placement wrong");
  a_enable_write: assert property (
    sfrWrite && sfrAddr == dual_dac_pkg::CTRL_ADDR[1] |=> convEnable1 == $past(sfrWdata[7]))
    else $error("enable bit not taken");
  // both directions: a disabled converter is off, an enabled one drives its output
  a_disabled_off: assert property (
    convOutEnableN0 == !convEnable0 && convShutdown0 == !convEnable0)
    else $error("converter 0 output control disagrees with enable");
  a_conv1_off: assert property (
    convOutEnableN1 == !convEnable1 && convShutdown1 == !convEnable1)
    else $error("converter 1 output control disagrees with enable");
  a_ctrl_unused: assert property (
    sfrRead && sfrAddr == dual_dac_pkg::CTRL_ADDR[0] |=> sfrRdata[6:3] == 4'h0)
    else $error("unused control bits read nonzero");
  // write, one idle cycle, then read back: the spacing the core leaves between accesses
  a_data_readback: assert property (
    sfrWrite && sfrAddr == dual_dac_pkg::LOW_ADDR[1] ##1 !sfrWrite ##1
    sfrRead && sfrAddr == dual_dac_pkg::LOW_ADDR[1] && !sfrWrite
    |=> sfrRdata == $past(sfrWdata, 3))
    else $error("low byte readback wrong");

  // main scenarios: full write pair, enabled output, five-bit format, switch-off
  c_full_write: cover property (
    sfrWrite && sfrAddr == dual_dac_pkg::LOW_ADDR[0] ##2
    sfrWrite && sfrAddr == dual_dac_pkg::HIGH_ADDR[0]);
  c_enable_on: cover property (convEnable1 && convCode1 != 12'h000);
  c_fmt_five: cover property (
    sfrWrite && sfrAddr == dual_dac_pkg::HIGH_ADDR[0] && stateQ.fmt[0] == 3'h1);
  c_conv0_off: cover property ($fell(convEnable0));

endmodule : dual_dac_latch

// file: verification/core_bus_model.sv
// core-side register bus master for the converter latch bench
// assumes strobes are sampled on rising mclk
`timescale 1ns/100ps
module core_bus_model (
  // clock
  input  wire logic       mclk,
  // register bus
  output logic      [7:0] sfrAddr,
  output logic            sfrWrite,
  output logic            sfrRead,
  output logic      [7:0] sfrWdata,
  input  wire logic [7:0] sfrRdata
);
  // idle bus from time zero
  initial begin
    sfrAddr  = 8'h00;
    sfrWrite = 1'b0;
    sfrRead  = 1'b0;
    sfrWdata = 8'h00;
  end
  // data inverted after release so a stale byte never matches
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) #1;
    sfrAddr  = a;
    sfrWdata = d;
    sfrWrite = 1'b1;
    @(posedge mclk) #1;
    sfrWrite = 1'b0;
    sfrWdata = ~d;
  endtask : wr
  // read data holds from the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk) #1;
    sfrAddr = a;
    sfrRead = 1'b1;
    @(posedge mclk) #1;
    sfrRead = 1'b0;
    d       = sfrRdata;
  endtask : rd
  // low byte first
  // k is the number of upper code bits carried by the high byte
  task automatic put12(input int n, input int k, input logic [11:0] c);
    wr(dual_dac_pkg::LOW_ADDR[n], 8'(c << (k - 4)));
    wr(dual_dac_pkg::HIGH_ADDR[n], 8'(c >> (12 - k)));
  endtask : put12
endmodule : core_bus_model

// file: verification/tb.sv
// self-checking bench: both converters, every format, enable, reset values
// assumes core_bus_model is the only master on the register bus
`timescale 1ns/100ps
module tb;
  // clock, reset and bus
  logic        mclk  = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  sfrAddr;
  logic [7:0]  sfrWdata;
  logic [7:0]  sfrRdata;
  logic        sfrWrite;
  logic        sfrRead;
  logic        hit;
  // converter controls by index
  logic [11:0] code [2];
  logic [1:0]  en;
  logic [1:0]  oeN;
  logic [1:0]  sd;
  logic [7:0]  rv;
  logic [2:0]  fmt;
  int          err_total = 0;
  int          n_tests   = 0;
  // range ends included
  logic [11:0] codes [5] = '{12'hfff, 12'h000, 12'ha5c, 12'h5a3, 12'hc3c};
  // 8 ns clock
  always #4 mclk = ~mclk;
  dual_dac_latch i_dut (
    .mclk(mclk), .reset(reset), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
    .sfrRead(sfrRead), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .sfrHit(hit),
    .convCode0(code[0]), .convEnable0(en[0]), .convOutEnableN0(oeN[0]),
    .convShutdown0(sd[0]), .convCode1(code[1]), .convEnable1(en[1]),
    .convOutEnableN1(oeN[1]), .convShutdown1(sd[1]));
  core_bus_model i_core (
    .mclk(mclk), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite), .sfrRead(sfrRead),
    .sfrWdata(sfrWdata), .sfrRdata(sfrRdata));
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  // watchdog far beyond the roughly 124 cycles needed
  initial begin
    #100000;
    err_total++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    repeat (5) @(posedge mclk);
    #1 reset = 1'b0;
    for (int n = 0; n < 2; n++) begin
      i_core.rd(dual_dac_pkg::LOW_ADDR[n], rv);
      chk({4'h0, rv}, 12'h000);
      i_core.rd(dual_dac_pkg::CTRL_ADDR[n], rv);
      chk({4'h0, rv}, 12'h000);
      chk({9'h0, en[n], oeN[n], sd[n]}, 12'h003);
      chk({11'h0, hit}, 12'h001);
      // bias and reference taken as set by software
      for (int f = 0; f < 5; f++) begin
        fmt = (f < 4) ? 3'(f) : 3'h7;
        i_core.wr(dual_dac_pkg::CTRL_ADDR[n], {5'h1f, fmt});
        i_core.put12(n, f + 4, codes[f]);
        chk(code[n], codes[f]);
        i_core.rd(dual_dac_pkg::CTRL_ADDR[n], rv);
        chk({4'h0, rv}, {4'h0, 5'h10, fmt});
        chk({9'h0, en[n], oeN[n], sd[n]}, 12'h004);
      end
      // eight-bit use: fixed low byte, high byte only
      i_core.wr(dual_dac_pkg::LOW_ADDR[n], 8'h00);
      chk(code[n], codes[4]);
      i_core.rd(dual_dac_pkg::LOW_ADDR[n], rv);
      chk({4'h0, rv}, 12'h000);
      i_core.wr(dual_dac_pkg::HIGH_ADDR[n], 8'h5a);
      chk(code[n], 12'h5a0);
      i_core.rd(dual_dac_pkg::HIGH_ADDR[n], rv);
      chk({4'h0, rv}, 12'h05a);
      chk({11'h0, hit}, 12'h001);
      i_core.wr(dual_dac_pkg::CTRL_ADDR[n], 8'h00);
      chk({9'h0, en[n], oeN[n], sd[n]}, 12'h003);
      // format change alone keeps the code
      chk(code[n], 12'h5a0);
    end
    chk(code[0], 12'h5a0);
    i_core.rd(8'hd8, rv);
    chk({4'h0, rv}, 12'h000);
    chk({11'h0, hit}, 12'h000);
    // second reset in mid-run clears every register
    i_core.wr(dual_dac_pkg::CTRL_ADDR[0], 8'h81);
    @(posedge mclk) #1 reset = 1'b1;
    repeat (2) @(posedge mclk);
    #1 reset = 1'b0;
    chk(code[0], 12'h000);
    chk(code[1], 12'h000);
    chk({9'h0, en[0], oeN[0], sd[0]}, 12'h003);
    i_core.rd(dual_dac_pkg::HIGH_ADDR[1], rv);
    chk({4'h0, rv}, 12'h000);
    i_core.rd(dual_dac_pkg::CTRL_ADDR[0], rv);
    chk({4'h0, rv}, 12'h000);
    tally_and_finish();
  end
endmodule : tb
